// file: verilog/hfw_buffer.sv
// Byte buffer with watermark flags behind an AXI4-Lite slave.
// Assumes one clock, synchronous active-low reset, well-behaved master.
`timescale 1ns/10ps
module hfw_buffer
#(
  parameter int ADDR_W = 8
)(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Interrupt
  output logic                   irq
);
  import hfw_pkg::*;

  hfw_state_type r;
  hfw_state_type n;
  logic [7:0]    mem [0:511];
  logic [9:0]    depth;
  logic [9:0]    thr;
  logic [9:0]    free_cnt;
  logic          near_full;
  logic          near_empty;
  logic          full;
  logic          do_wr;
  logic          do_rd;
  logic [5:0]    rd_idx;
  logic          flush;
  logic          push;
  logic          pop;
  logic [3:0]    irq_set;
  logic [3:0]    irq_clr;

  assign depth = r.size255 ? DEPTH_SMALL : DEPTH_LARGE;
  // Extension bit ignored in 255-byte mode
  assign thr = r.size255 ? {2'h0, r.lvl}
                         : {1'h0, r.lvl_msb, r.lvl};
  assign free_cnt   = depth - r.cnt;
  assign near_full  = free_cnt <= thr;
  assign near_empty = r.cnt <= thr;
  assign full       = r.cnt >= depth;

  // Write runs once both address and data are held
  assign do_wr  = r.aw_have & r.w_have & ~r.bvalid;
  assign do_rd  = arvalid & ~r.rvalid;
  assign rd_idx = araddr[7:2];
  assign flush  = do_wr & r.wstb & (r.aw_idx == IDX_CTRL)
                & r.wdat[BIT_FLUSH];
  assign push   = do_wr & r.wstb & (r.aw_idx == IDX_DATA) & ~full;
  assign pop    = do_rd & (rd_idx == IDX_DATA) & (r.cnt != 10'h000);

  assign irq_set[IRQ_NFULL] = near_full & ~r.nf_d;
  assign irq_set[IRQ_NEMPT] = near_empty & ~r.ne_d;
  assign irq_set[IRQ_OVFL]  = do_wr & r.wstb & (r.aw_idx == IDX_DATA)
                            & full;
  assign irq_set[IRQ_UNFL]  = do_rd & (rd_idx == IDX_DATA)
                            & (r.cnt == 10'h000);
  assign irq_clr = (do_wr & r.wstb & (r.aw_idx == IDX_IRQ_CL))
                 ? r.wdat[3:0] : 4'h0;

  assign awready = ~r.aw_have;
  assign wready  = ~r.w_have;
  assign arready = ~r.rvalid;
  assign bvalid  = r.bvalid;
  assign bresp   = r.bresp;
  assign rvalid  = r.rvalid;
  assign rdata   = r.rdata;
  assign rresp   = r.rresp;
  assign irq     = |(r.irq_st & r.irq_en);

  always_comb
  begin
    n = r;
    n.nf_d = near_full;
    n.ne_d = near_empty;
    // Set beats clear when both land together
    n.irq_st = (r.irq_st & ~irq_clr) | irq_set;
    if (awvalid && !r.aw_have)
    begin
      n.aw_have = 1'b1;
      n.aw_idx  = awaddr[7:2];
    end
    if (wvalid && !r.w_have)
    begin
      n.w_have = 1'b1;
      n.wdat   = wdata[7:0];
      n.wstb   = wstrb[0];
    end
    if (r.bvalid && bready)
    begin
      n.bvalid  = 1'b0;
      n.aw_have = 1'b0;
      n.w_have  = 1'b0;
    end
    if (r.rvalid && rready)
      n.rvalid = 1'b0;
    if (push)
      n.wp = r.wp + 9'h001;
    if (pop)
      n.rp = r.rp + 9'h001;
    n.cnt = r.cnt + {9'h000, push} - {9'h000, pop};
    if (do_wr)
    begin
      n.bvalid = 1'b1;
      n.bresp  = RESP_OKAY;
      if (r.aw_idx != IDX_DATA)
        n.ptr = r.aw_idx + 6'h01;
      if (r.wstb)
      begin
        case (r.aw_idx)
          IDX_CTRL:
          begin
            n.size255 = r.wdat[BIT_SIZE];
            n.lvl_msb = r.wdat[BIT_TMSB];
          end
          IDX_THR:    n.lvl    = r.wdat;
          IDX_IRQ_EN: n.irq_en = r.wdat[3:0];
          IDX_DATA, IDX_CNT, IDX_IRQ_ST, IDX_IRQ_CL, IDX_PTR: ;
          default:    n.bresp  = RESP_SLVERR;
        endcase
      end
    end
    if (do_rd)
    begin
      n.rvalid = 1'b1;
      n.rresp  = RESP_OKAY;
      n.rdata  = 32'h0;
      if (rd_idx != IDX_DATA)
        n.ptr = rd_idx + 6'h01;
      case (rd_idx)
        IDX_CTRL:
        begin
          // Flush bit always reads zero
          n.rdata[7:0] = {r.size255, near_full, near_empty, 1'b0,
                          1'b0, r.lvl_msb, r.cnt[9:8]};
        end
        IDX_THR:    n.rdata[7:0] = r.lvl;
        IDX_CNT:    n.rdata[7:0] = r.cnt[7:0];
        IDX_DATA:   n.rdata[7:0] = pop ? mem[r.rp] : 8'h00;
        IDX_IRQ_ST: n.rdata[3:0] = r.irq_st;
        IDX_IRQ_EN: n.rdata[3:0] = r.irq_en;
        IDX_IRQ_CL: ;
        IDX_PTR:    n.rdata[5:0] = r.ptr;
        default:    n.rresp = RESP_SLVERR;
      endcase
    end
    // Flush overrides any same-cycle pop
    if (flush)
    begin
      n.rp  = 9'h000;
      n.wp  = 9'h000;
      n.cnt = CNT_RST;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      r         <= '0;
      r.size255 <= SIZE_RST;
      r.lvl     <= LVL_RST;
      r.cnt     <= CNT_RST;
    end
    else
      r <= n;
  end

  // Storage left unreset; contents only meaningful below the count
  always_ff @(posedge aclk)
  begin
    if (push)
      mem[r.wp] <= r.wdat;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic ctrl_rd;
  logic ctrl_wr;
  assign ctrl_rd = do_rd & (rd_idx == IDX_CTRL);
  assign ctrl_wr = do_wr & r.wstb & (r.aw_idx == IDX_CTRL);

  property p_depth;
    ctrl_wr |=> depth == (r.wdat[BIT_SIZE] ? 10'h0ff : 10'h200);
  endproperty
  a_depth: assert property (p_depth)
    else $error("depth does not follow size bit");

  property p_nfull;
    ctrl_rd |=> r.rdata[BIT_NFULL] ==
      (($past(depth) - $past(r.cnt)) <= $past(thr));
  endproperty
  a_nfull: assert property (p_nfull)
    else $error("near-full read wrong");

  property p_nempty;
    ctrl_rd |=> r.rdata[BIT_NEMPT] == ($past(r.cnt) <= $past(thr));
  endproperty
  a_nempty: assert property (p_nempty)
    else $error("near-empty read wrong");

  property p_flush;
    flush |=> r.cnt == 10'h000 && r.rp == 9'h000 && r.wp == 9'h000;
  endproperty
  a_flush: assert property (p_flush)
    else $error("flush did not empty buffer");

  property p_flush_rd;
    ctrl_rd |=> !r.rdata[BIT_FLUSH] && r.rvalid;
  endproperty
  a_flush_rd: assert property (p_flush_rd)
    else $error("flush bit read nonzero");

  property p_thrmsb;
    r.size255 |-> thr[9:8] == 2'h0;
  endproperty
  a_thrmsb: assert property (p_thrmsb)
    else $error("threshold msb used in small mode");

  property p_cntext;
    ctrl_rd |=> r.rdata[1:0] == $past(r.cnt[9:8]);
  endproperty
  a_cntext: assert property (p_cntext)
    else $error("count extension read wrong");

  property p_lvl;
    do_wr && r.wstb && r.aw_idx == IDX_THR |=> r.lvl == $past(r.wdat);
  endproperty
  a_lvl: assert property (p_lvl)
    else $error("threshold not stored");

  property p_cntrd;
    do_rd && rd_idx == IDX_CNT |=> r.rdata[7:0] == $past(r.cnt[7:0]);
  endproperty
  a_cntrd: assert property (p_cntrd)
    else $error("count read wrong");

  property p_count;
    (push && !pop) |=> r.cnt == $past(r.cnt) + 10'h001;
  endproperty
  a_count: assert property (p_count)
    else $error("count not incremented");

  property p_ptr;
    do_wr && r.aw_idx == IDX_DATA && !do_rd |=> r.ptr == $past(r.ptr);
  endproperty
  a_ptr: assert property (p_ptr)
    else $error("data access moved pointer");

  // A write into a full buffer is dropped, not wrapped over old bytes
  property p_ovfl;
    do_wr && r.wstb && r.aw_idx == IDX_DATA && full && !pop
      |=> r.cnt == $past(r.cnt);
  endproperty
  a_ovfl: assert property (p_ovfl)
    else $error("write to full buffer changed count");

  property p_pop;
    (pop && !push && !flush) |=> r.cnt == $past(r.cnt) - 10'h001;
  endproperty
  a_pop: assert property (p_pop)
    else $error("count not decremented");

  property p_ptr_inc;
    do_rd && rd_idx != IDX_DATA |=> r.ptr == $past(rd_idx) + 6'h01;
  endproperty
  a_ptr_inc: assert property (p_ptr_inc)
    else $error("address pointer not advanced");

  property p_ne_irq;
    irq_set[IRQ_NEMPT] |=> r.irq_st[IRQ_NEMPT];
  endproperty
  a_ne_irq: assert property (p_ne_irq)
    else $error("near-empty event lost");

  c_flush: cover property (flush);
  c_full:  cover property (push ##1 full);
  c_nfull: cover property (irq_set[IRQ_NFULL]);
  c_pop:   cover property (pop);
endmodule

// file: verilog/hfw_pkg.sv
// Constants for the host data buffer with watermark flags.
// Assumes a 32-bit AXI4-Lite register bus; word index = byte addr / 4.
package hfw_pkg;
  // Register word indices
  localparam logic [5:0] IDX_CTRL  = 6'h02;
  localparam logic [5:0] IDX_THR   = 6'h03;
  localparam logic [5:0] IDX_CNT   = 6'h04;
  localparam logic [5:0] IDX_DATA  = 6'h05;
  localparam logic [5:0] IDX_IRQ_ST = 6'h10;
  localparam logic [5:0] IDX_IRQ_EN = 6'h11;
  localparam logic [5:0] IDX_IRQ_CL = 6'h12;
  localparam logic [5:0] IDX_PTR   = 6'h13;
  // Control register fields
  localparam int BIT_SIZE  = 7;
  localparam int BIT_NFULL = 6;
  localparam int BIT_NEMPT = 5;
  localparam int BIT_FLUSH = 4;
  localparam int BIT_TMSB  = 2;
  // Interrupt status bits
  localparam int IRQ_NFULL = 0;
  localparam int IRQ_NEMPT = 1;
  localparam int IRQ_OVFL  = 2;
  localparam int IRQ_UNFL  = 3;
  // Depths, reset values and response codes
  localparam logic [9:0] DEPTH_SMALL = 10'h0ff;
  localparam logic [9:0] DEPTH_LARGE = 10'h200;
  localparam logic       SIZE_RST    = 1'h0;
  localparam logic [7:0] LVL_RST     = 8'h08;
  localparam logic [9:0] CNT_RST     = 10'h000;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [9:0]  cnt;
    logic [8:0]  rp;
    logic [8:0]  wp;
    logic        size255;
    logic [7:0]  lvl;
    logic        lvl_msb;
    logic        aw_have;
    logic [5:0]  aw_idx;
    logic        w_have;
    logic [7:0]  wdat;
    logic        wstb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [3:0]  irq_st;
    logic [3:0]  irq_en;
    logic        nf_d;
    logic        ne_d;
    logic [5:0]  ptr;
  } hfw_state_type;
endpackage

// file: dv/hfw_host.sv
// Host master model: AXI4-Lite write and read tasks for the bench.
// Assumes one clock; tasks are entered just after a rising edge.
`timescale 1ns/10ps
module hfw_host (
  // Clock
  input  wire logic        aclk,
  // Write channels
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic        bvalid,
  input  wire logic [1:0]  bresp,
  output logic             bready,
  // Read channels
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  // Write response of the last completed write
  logic [1:0] wr_resp;
  // Response ready held high, so no task ever toggles it
  initial
  begin
    {awaddr, awvalid, wdata, wvalid, araddr, arvalid} = '0;
    wstrb  = 4'hf;
    bready = 1'b1;
    rready = 1'b1;
  end
  // Address and data may be taken at different edges
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic ga;
    logic gw;
    ga = 1'b0;
    gw = 1'b0;
    awaddr  <= a;
    wdata   <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!(ga && gw))
    begin
      @(posedge aclk);
      ga = ga | awready;
      gw = gw | wready;
      awvalid <= !ga;
      wvalid  <= !gw;
    end
    do @(posedge aclk); while (!bvalid);
    wr_resp = bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
  endtask
endmodule

// file: dv/tb.sv
// Bench for the watermark buffer: register sequences with expectations.
// Assumes the host model drives the bus and checks run in order.
`timescale 1ns/10ps
module tb;
  import hfw_pkg::*;
  logic             aclk;
  logic             aresetn;
  wire logic [7:0]  awaddr, araddr;
  wire logic [31:0] wdata, rdata;
  wire logic [3:0]  wstrb;
  wire logic [1:0]  rresp, bresp;
  wire logic        awvalid, awready, wvalid, wready, bvalid, bready;
  wire logic        arvalid, arready, rvalid, rready, irq;
  int               bad_count = 0;
  int               n_checks = 0;
  logic [31:0]      d;
  logic [1:0]       r;

  hfw_buffer u_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq);
  hfw_host u_host (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bvalid, .bresp, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rc(input logic [5:0] i, input logic [31:0] e);
    u_host.rd({i, 2'h0}, d, r);
    chk(d, e);
  endtask
  task automatic wi(input logic [5:0] i, input logic [7:0] v);
    u_host.wr({i, 2'h0}, v);
  endtask
  task automatic push(input int n);
    for (int k = 0; k < n; k++)
      wi(IDX_DATA, k[7:0] + 8'h01);
  endtask
  // Status sets a cycle after its cause; give it margin
  task automatic settle;
    repeat (2) @(posedge aclk);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  initial
  begin
    #100000;
    bad_count++;
    final_report;
  end
  initial
  begin
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(IDX_CTRL, 32'h20);
    rc(IDX_THR, 32'h08);
    wi(IDX_CNT, 8'h55);
    rc(IDX_CNT, 32'h00);
    $display("test reset done");
    push(10);
    rc(IDX_CNT, 32'h0a);
    rc(IDX_CTRL, 32'h00);
    rc(IDX_DATA, 32'h01);
    rc(IDX_DATA, 32'h02);
    rc(IDX_CNT, 32'h08);
    rc(IDX_CTRL, 32'h20);
    wi(IDX_DATA, 8'h33);
    rc(IDX_DATA, 32'h03);
    rc(IDX_PTR, 32'h03);
    rc(IDX_PTR, 32'h14);
    $display("test data port done");
    wi(IDX_CTRL, 8'h10);
    rc(IDX_CNT, 32'h00);
    wi(IDX_CTRL, 8'h80);
    rc(IDX_CTRL, 32'ha0);
    wi(IDX_THR, 8'hf5);
    push(10);
    rc(IDX_CTRL, 32'he0);
    wi(IDX_THR, 8'hf4);
    rc(IDX_CTRL, 32'ha0);
    wi(IDX_CTRL, 8'h84);
    rc(IDX_CTRL, 32'ha4);
    push(245);
    wi(IDX_DATA, 8'hee);
    rc(IDX_CNT, 32'hff);
    $display("test small depth done");
    wi(IDX_CTRL, 8'h94);
    wi(IDX_CTRL, 8'h04);
    wi(IDX_THR, 8'h00);
    push(260);
    rc(IDX_CNT, 32'h04);
    rc(IDX_CTRL, 32'h45);
    wi(IDX_CTRL, 8'h10);
    rc(IDX_CTRL, 32'h20);
    rc(IDX_CNT, 32'h00);
    $display("test large depth done");
    wi(IDX_IRQ_CL, 8'h0f);
    rc(IDX_DATA, 32'h00);
    settle;
    chk({31'h0, irq}, 32'h0);
    wi(IDX_IRQ_EN, 8'h08);
    settle;
    chk({31'h0, irq}, 32'h1);
    u_host.rd({IDX_IRQ_ST, 2'h0}, d, r);
    chk(d, 32'h8);
    wi(IDX_IRQ_CL, 8'h08);
    settle;
    chk({31'h0, irq}, 32'h0);
    $display("test interrupt done");
    u_host.rd(8'h7c, d, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wi(6'h1f, 8'h00);
    chk({30'h0, u_host.wr_resp}, {30'h0, RESP_SLVERR});
    rc(IDX_PTR, 32'h20);
    $display("test unmapped done");
    final_report;
  end
endmodule
